/* hdl/adcdg_regs.svh */
/*
  Constants for the ADC DMA port gating and calibration block: special
  function register addresses, field positions, reset values and counts.
  Assumes it is included by bare name from the package and the modules.
*/
// How it works
// [R1] While DMA capture runs, core drives aimed at ports 0 and 2 never reach those pins.
// [R2] The core is never stalled; a blocked external access completes as if it had run.
// [R3] When the DMA controller reports a finished block, an interrupt request is raised.
// [R4] The offset coefficient is one 14-bit value split into a 6-bit high and 8-bit low register.
// [R5] The gain coefficient is one 14-bit value split into a 6-bit high and 8-bit low register.
// [R6] A larger offset coefficient pushes output codes down, a smaller one pushes them up.
// [R7] The offset coefficient range covers about plus or minus 6.25 percent of reference.
// [R8] A larger gain coefficient steepens the transfer slope, spanning about 0.969 to 1.031 reference.
// [R9] After every power-up the factory coefficients are copied from hidden storage first.
// [R10] Software starts DMA capture by setting bit six of the second ADC control register.
// [R11] DMA completion sets the ADC interrupt flag in hardware, which drives the request.
// [R12] Software may overwrite the coefficients and later conversions use the new values.
`ifndef ADCDG_REGS_SVH
`define ADCDG_REGS_SVH

// Special function register addresses
`define ADCDG_ADDR_CONTROL_TWO 8'hD8
`define ADCDG_ADDR_OFFSET_LOW 8'hF1
`define ADCDG_ADDR_OFFSET_HIGH 8'hF2
`define ADCDG_ADDR_GAIN_LOW 8'hF3
`define ADCDG_ADDR_GAIN_HIGH 8'hF4

// Control register fields
`define ADCDG_DMA_ENABLE_BIT 6
`define ADCDG_IRQ_FLAG_BIT 7
`define ADCDG_CONTROL_TWO_RESET 8'h00

// Coefficient store byte indices
`define ADCDG_IDX_OFFSET_LOW 2'd0
`define ADCDG_IDX_OFFSET_HIGH 2'd1
`define ADCDG_IDX_GAIN_LOW 2'd2
`define ADCDG_IDX_GAIN_HIGH 2'd3
`define ADCDG_COEF_BYTES 3'd4

// Coefficient arithmetic
`define ADCDG_COEF_MID 15'sh2000
`define ADCDG_OFFSET_SHIFT 5
`define ADCDG_GAIN_SHIFT 18
`define ADCDG_CODE_MAX 13'sh0FFF
`define ADCDG_COEF_RESET 8'h00

`endif

/* hdl/adcdg_pkg.sv */
/*
  Types for the ADC DMA port gating and calibration block.
  Assumes the constants header sits on the include path.
*/
`include "adcdg_regs.svh"

package adcdg_pkg;

  // Drive of one 8-bit external port
  typedef struct packed {
    logic [7:0] data;
    logic oe;
  } adcdg_port_t;

  // Special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } adcdg_sfr_t;

  // Power-up coefficient loader
  typedef enum logic [1:0] {
    ADCDG_LD_REQ,
    ADCDG_LD_WAIT,
    ADCDG_LD_DONE
  } adcdg_load_t;

endpackage

/* hdl/adcdg_coef_mem.sv */
/*
  Four-byte coefficient store: offset low/high and gain low/high.
  Assumes one writer per cycle, selected by the caller; read data is
  registered, all bytes are also presented in parallel.
*/
`timescale 1ns/100ps

module adcdg_coef_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_idx,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [1:0] rd_idx,
  output logic [7:0] rd_data,
  // Parallel view
  output logic [31:0] all_bytes
);

  logic [7:0] mem_q [0:3];

  // Byte storage, high registers keep six bits only
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_byte
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          mem_q[gi] <= `ADCDG_COEF_RESET;
        end else if (wr_en && wr_idx == 2'(gi)) begin
          mem_q[gi] <= (gi % 2 == 1) ? {2'b00, wr_data[5:0]} : wr_data; // [R4] [R5]
        end
      end
      assign all_bytes[gi*8 +: 8] = mem_q[gi];
    end
  endgenerate

  // Registered read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_idx];
    end
  end

endmodule

/* hdl/adcdg_top.sv */
/*
  ADC DMA external port gating, completion flag and offset/gain
  calibration coefficients with power-up load and result correction.
  Assumes core, DMA controller, hidden store and SFR bus all run on
  core_clk; the DMA controller reports block completion as a pulse.
*/
`timescale 1ns/100ps
`include "adcdg_regs.svh"

module adcdg_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Special function register access
  input wire adcdg_pkg::adcdg_sfr_t sfr,
  output logic [7:0] sfr_rdata,
  // Core drive of ports 0 and 2
  input wire adcdg_pkg::adcdg_port_t core_port0,
  input wire adcdg_pkg::adcdg_port_t core_port2,
  input wire logic core_xacc_req,
  output logic core_xacc_done,
  output logic core_xacc_blocked,
  // DMA controller drive of ports 0 and 2
  input wire adcdg_pkg::adcdg_port_t dma_port0,
  input wire adcdg_pkg::adcdg_port_t dma_port2,
  input wire logic dma_block_done,
  output logic dma_enable,
  // Port pins
  output adcdg_pkg::adcdg_port_t pin_port0,
  output adcdg_pkg::adcdg_port_t pin_port2,
  // Interrupt request to core
  output logic adc_irq_req,
  // Hidden coefficient storage
  output logic nv_rd_req,
  output logic [1:0] nv_rd_idx,
  input wire logic nv_rd_valid,
  input wire logic [7:0] nv_rd_data,
  output logic cal_loaded,
  // Raw conversion in, corrected out
  input wire logic raw_valid,
  input wire logic [11:0] raw_code,
  output logic cor_valid,
  output logic [11:0] cor_code,
  // Coefficient values in force
  output logic [13:0] offset_coef,
  output logic [13:0] gain_coef
);

  // Map an SFR address onto a coefficient byte index
  function automatic logic [2:0] coef_decode(input logic [7:0] a);
    unique case (a)
      `ADCDG_ADDR_OFFSET_LOW: coef_decode = {1'b1, `ADCDG_IDX_OFFSET_LOW};
      `ADCDG_ADDR_OFFSET_HIGH: coef_decode = {1'b1, `ADCDG_IDX_OFFSET_HIGH};
      `ADCDG_ADDR_GAIN_LOW: coef_decode = {1'b1, `ADCDG_IDX_GAIN_LOW};
      `ADCDG_ADDR_GAIN_HIGH: coef_decode = {1'b1, `ADCDG_IDX_GAIN_HIGH};
      default: coef_decode = 3'b000;
    endcase
  endfunction

  logic dma_en_q;
  logic irq_flag_q;
  logic [2:0] wr_hit;
  logic [2:0] rd_hit;
  logic ctl_wr;
  adcdg_pkg::adcdg_load_t ld_q;
  logic [1:0] ld_idx_q;
  logic mem_wr;
  logic [1:0] mem_wr_idx;
  logic [7:0] mem_wr_data;
  logic [7:0] mem_rd_data;
  logic [31:0] coef_bytes;
  logic rd_coef_q;
  logic rd_ctl_q;
  logic [7:0] ctl_rd_q;
  // Control reset image, held so single bits can be selected
  localparam logic [7:0] CTL_RESET = `ADCDG_CONTROL_TWO_RESET;

  assign wr_hit = coef_decode(sfr.addr);
  assign rd_hit = wr_hit;
  assign ctl_wr = sfr.wr && sfr.addr == `ADCDG_ADDR_CONTROL_TWO;

  // DMA enable bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dma_en_q <= CTL_RESET[`ADCDG_DMA_ENABLE_BIT];
    end else if (ctl_wr) begin
      dma_en_q <= sfr.wdata[`ADCDG_DMA_ENABLE_BIT]; // [R10]
    end
  end
  assign dma_enable = dma_en_q;

  // Completion flag, hardware set beats software clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_flag_q <= CTL_RESET[`ADCDG_IRQ_FLAG_BIT];
    end else if (dma_block_done) begin
      irq_flag_q <= 1'b1; // [R11]
    end else if (ctl_wr) begin
      irq_flag_q <= sfr.wdata[`ADCDG_IRQ_FLAG_BIT];
    end
  end
  assign adc_irq_req = irq_flag_q; // [R3]

  // Port pins: DMA owns them while enabled, core drives suppressed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_port0 <= '0;
      pin_port2 <= '0;
    end else if (dma_en_q) begin
      pin_port0 <= dma_port0; // [R1]
      pin_port2 <= dma_port2; // [R1]
    end else begin
      pin_port0 <= core_port0;
      pin_port2 <= core_port2;
    end
  end

  // Core access always completes at once, flagged when gated off
  assign core_xacc_done = core_xacc_req; // [R2]
  assign core_xacc_blocked = core_xacc_req && dma_en_q;

  // Power-up loader walks the four coefficient bytes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ld_q <= adcdg_pkg::ADCDG_LD_REQ;
      ld_idx_q <= 2'd0;
    end else begin
      unique case (ld_q)
        adcdg_pkg::ADCDG_LD_REQ: begin
          ld_q <= adcdg_pkg::ADCDG_LD_WAIT;
        end
        adcdg_pkg::ADCDG_LD_WAIT: begin
          if (nv_rd_valid) begin
            ld_idx_q <= ld_idx_q + 2'd1; // [R9]
            ld_q <= (ld_idx_q == 2'(`ADCDG_COEF_BYTES - 3'd1)) ?
              adcdg_pkg::ADCDG_LD_DONE : adcdg_pkg::ADCDG_LD_REQ;
          end
        end
        adcdg_pkg::ADCDG_LD_DONE: begin
          ld_q <= adcdg_pkg::ADCDG_LD_DONE;
        end
        default: begin
          ld_q <= adcdg_pkg::ADCDG_LD_REQ;
        end
      endcase
    end
  end
  assign nv_rd_req = ld_q == adcdg_pkg::ADCDG_LD_REQ;
  assign nv_rd_idx = ld_idx_q;
  assign cal_loaded = ld_q == adcdg_pkg::ADCDG_LD_DONE;

  // Store writer: loader first, software after load completes
  always_comb begin
    if (ld_q == adcdg_pkg::ADCDG_LD_WAIT) begin
      mem_wr = nv_rd_valid; // [R9]
      mem_wr_idx = ld_idx_q;
      mem_wr_data = nv_rd_data;
    end else begin
      mem_wr = sfr.wr && wr_hit[2] && cal_loaded; // [R12]
      mem_wr_idx = wr_hit[1:0];
      mem_wr_data = sfr.wdata;
    end
  end

  adcdg_coef_mem u_coef (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(mem_wr),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_idx(rd_hit[1:0]),
    .rd_data(mem_rd_data),
    .all_bytes(coef_bytes)
  );

  // Join high and low bytes into 14-bit coefficients
  assign offset_coef = {coef_bytes[13:8], coef_bytes[7:0]}; // [R4]
  assign gain_coef = {coef_bytes[29:24], coef_bytes[23:16]}; // [R5]

  // Registered read return
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_coef_q <= 1'b0;
      rd_ctl_q <= 1'b0;
      ctl_rd_q <= 8'h00;
    end else begin
      rd_coef_q <= sfr.rd && rd_hit[2];
      rd_ctl_q <= sfr.rd && sfr.addr == `ADCDG_ADDR_CONTROL_TWO;
      ctl_rd_q <= {irq_flag_q, dma_en_q, 6'b00_0000};
    end
  end
  assign sfr_rdata = rd_coef_q ? mem_rd_data : (rd_ctl_q ? ctl_rd_q : 8'h00);

  // Correction: gain around mid-scale, then subtract offset around mid-scale
  logic signed [14:0] off_dev;
  logic signed [14:0] gain_dev;
  logic signed [27:0] gain_prod;
  // Two bits above the code range so a top-end sum cannot wrap negative
  logic signed [13:0] cor_sum;
  assign off_dev = $signed({1'b0, offset_coef}) - `ADCDG_COEF_MID;
  assign gain_dev = $signed({1'b0, gain_coef}) - `ADCDG_COEF_MID;
  assign gain_prod = $signed({1'b0, raw_code}) * gain_dev; // [R8]
  assign cor_sum = 14'($signed({2'b00, raw_code}) + 14'(gain_prod >>> `ADCDG_GAIN_SHIFT)
    - 14'(off_dev >>> `ADCDG_OFFSET_SHIFT)); // [R6] [R7]

  // Clamp and register corrected result
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cor_valid <= 1'b0;
      cor_code <= 12'h000;
    end else begin
      cor_valid <= raw_valid;
      if (raw_valid) begin
        if (cor_sum < 0) begin
          cor_code <= 12'h000;
        end else if (cor_sum > `ADCDG_CODE_MAX) begin
          cor_code <= 12'hFFF;
        end else begin
          cor_code <= cor_sum[11:0]; // [R12]
        end
      end
    end
  end

endmodule

/* verification/adcdg_nv_model.sv */
/*
  Hidden coefficient store model for the power-up loader.
  Assumes one request at a time; answers DLY+1 cycles after it.
*/
`timescale 1ns/100ps

module adcdg_nv_model #(
  parameter int DLY = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Loader handshake
  input wire logic nv_rd_req,
  input wire logic [1:0] nv_rd_idx,
  output logic nv_rd_valid,
  output logic [7:0] nv_rd_data
);
  // Factory bytes, gain high down to offset low
  localparam logic [31:0] ROM = 32'h1F78_2034;
  logic [1:0] idx_q;
  int cnt_q;

  // Late answer; data churns while nothing stands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      idx_q <= 2'd0;
      nv_rd_valid <= 1'b0;
      nv_rd_data <= 8'h00;
    end else begin
      nv_rd_valid <= 1'b0;
      nv_rd_data <= ~nv_rd_data;
      if (nv_rd_req) begin
        idx_q <= nv_rd_idx;
        cnt_q <= DLY;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
          nv_rd_valid <= 1'b1;
          nv_rd_data <= ROM[{idx_q, 3'b000} +: 8];
        end
      end
    end
  end
endmodule

/* verification/adcdg_check_sva.sv */
/*
  Port checker for gating, flag, loader and correction timing.
  Assumes it is bound onto adcdg_top; one clock, async reset.
*/
`timescale 1ns/100ps
`include "adcdg_regs.svh"

module adcdg_check (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire adcdg_pkg::adcdg_sfr_t sfr,
  input wire adcdg_pkg::adcdg_port_t core_port0,
  input wire adcdg_pkg::adcdg_port_t dma_port0,
  input wire adcdg_pkg::adcdg_port_t dma_port2,
  input wire adcdg_pkg::adcdg_port_t pin_port0,
  input wire adcdg_pkg::adcdg_port_t pin_port2,
  input wire logic core_xacc_req,
  input wire logic core_xacc_done,
  input wire logic core_xacc_blocked,
  input wire logic dma_block_done,
  input wire logic dma_enable,
  input wire logic adc_irq_req,
  input wire logic nv_rd_req,
  input wire logic cal_loaded,
  input wire logic raw_valid,
  input wire logic cor_valid,
  input wire logic [13:0] offset_coef,
  input wire logic [13:0] gain_coef
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic ctl_wr;
  // Control register write seen
  assign ctl_wr = sfr.wr && sfr.addr == `ADCDG_ADDR_CONTROL_TWO;

  a_gate_port0: assert property (dma_enable |=> pin_port0 == $past(dma_port0))
    else $error("port 0 not from dma");
  a_gate_port2: assert property (dma_enable |=> pin_port2 == $past(dma_port2))
    else $error("port 2 not from dma");
  a_core_pass: assert property (!dma_enable |=> pin_port0 == $past(core_port0))
    else $error("port 0 not from core");
  a_no_stall: assert property (core_xacc_req |-> core_xacc_done)
    else $error("core access stalled");
  a_block_mark: assert property (core_xacc_blocked == (core_xacc_req && dma_enable))
    else $error("blocked mark wrong");
  a_irq_set: assert property (dma_block_done |=> adc_irq_req)
    else $error("no irq after block");
  a_irq_hold: assert property (adc_irq_req && !ctl_wr |=> adc_irq_req)
    else $error("flag dropped");
  a_dma_bit: assert property (ctl_wr |=> dma_enable == $past(sfr.wdata[6]))
    else $error("dma enable bit wrong");
  a_coef_hold: assert property (cal_loaded && !sfr.wr |=> $stable(offset_coef)
    && $stable(gain_coef))
    else $error("coef moved");
  a_load_pulse: assert property (nv_rd_req |=> !nv_rd_req)
    else $error("load request held");
  a_cor_pulse: assert property (raw_valid |=> cor_valid)
    else $error("no result");
  // Main scenarios reached
  c_block: cover property (dma_block_done);
  c_set_wins: cover property (dma_block_done && ctl_wr);
  c_loaded: cover property ($rose(cal_loaded));
  c_gated: cover property (core_xacc_blocked);
endmodule

bind adcdg_top adcdg_check u_check (.core_clk, .rst, .sfr, .core_port0, .dma_port0,
  .dma_port2, .pin_port0, .pin_port2, .core_xacc_req, .core_xacc_done,
  .core_xacc_blocked, .dma_block_done, .dma_enable, .adc_irq_req, .nv_rd_req,
  .cal_loaded, .raw_valid, .cor_valid, .offset_coef, .gain_coef);

/* verification/adcdg_bench.sv */
/*
  Bench: register, loader, correction and port gating sequences.
  Assumes the checker binds itself; store model sits beside the design.
*/
`timescale 1ns/100ps
`include "adcdg_regs.svh"

module adc_dma_gating_and_calibration_bench;
  localparam logic [13:0] OFS [8] = '{14'h2000, 14'h2140, 14'h1EC0, 14'h0000, 14'h3FFF,
    14'h2000, 14'h2000, 14'h0000};
  localparam logic [13:0] GN [8] = '{14'h2000, 14'h2000, 14'h2000, 14'h2000, 14'h2000,
    14'h3000, 14'h1000, 14'h2000};
  localparam logic [11:0] RAW [8] = '{12'h123, 12'h123, 12'h123, 12'h000, 12'h050,
    12'h800, 12'h800, 12'hFFF};
  localparam logic [11:0] COR [8] = '{12'h123, 12'h119, 12'h12D, 12'h100, 12'h000,
    12'h820, 12'h7E0, 12'hFFF};
  localparam logic [7:0] RDX [6] = '{8'h34, 8'h20, 8'h78, 8'h1F, 8'h00, 8'h00};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  adcdg_pkg::adcdg_sfr_t sfr = '0;
  adcdg_pkg::adcdg_port_t core_port0 = '{8'hAA, 1'b1};
  adcdg_pkg::adcdg_port_t core_port2 = '{8'h55, 1'b1};
  adcdg_pkg::adcdg_port_t dma_port0 = '{8'h0F, 1'b1};
  adcdg_pkg::adcdg_port_t dma_port2 = '{8'hF0, 1'b1};
  adcdg_pkg::adcdg_port_t pin_port0, pin_port2;
  logic core_xacc_req = 1'b0;
  logic dma_block_done = 1'b0;
  logic raw_valid = 1'b0;
  logic [11:0] raw_code = 12'h000;
  logic [11:0] cor_code;
  logic [7:0] sfr_rdata, nv_rd_data, rd;
  logic [1:0] nv_rd_idx;
  logic core_xacc_done, core_xacc_blocked, dma_enable, adc_irq_req;
  logic nv_rd_req, nv_rd_valid, cal_loaded, cor_valid;
  logic [13:0] offset_coef, gain_coef;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  adcdg_top dut (.core_clk, .rst, .sfr, .sfr_rdata, .core_port0, .core_port2,
    .core_xacc_req, .core_xacc_done, .core_xacc_blocked, .dma_port0, .dma_port2,
    .dma_block_done, .dma_enable, .pin_port0, .pin_port2, .adc_irq_req, .nv_rd_req,
    .nv_rd_idx, .nv_rd_valid, .nv_rd_data, .cal_loaded, .raw_valid, .raw_code,
    .cor_valid, .cor_code, .offset_coef, .gain_coef);
  adcdg_nv_model #(.DLY(3)) nv (.core_clk, .rst, .nv_rd_req, .nv_rd_idx, .nv_rd_valid,
    .nv_rd_data);

  // Clock and hang ceiling
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr <= '{a, 1'b1, 1'b0, d};
    @(posedge core_clk);
    sfr <= '0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge core_clk);
    sfr <= '0;
    #1;
    d = sfr_rdata;
  endtask

  task automatic conv(input logic [13:0] o, input logic [13:0] g, input logic [11:0] r,
    input logic [11:0] e);
    wr(`ADCDG_ADDR_OFFSET_LOW, o[7:0]);
    wr(`ADCDG_ADDR_OFFSET_HIGH, {2'b00, o[13:8]});
    wr(`ADCDG_ADDR_GAIN_LOW, g[7:0]);
    wr(`ADCDG_ADDR_GAIN_HIGH, {2'b00, g[13:8]});
    @(posedge core_clk);
    raw_valid <= 1'b1;
    raw_code <= r;
    @(posedge core_clk);
    raw_valid <= 1'b0;
    #1;
    chk(cor_valid, 1'b1);
    chk(cor_code, e);
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 60 && cal_loaded !== 1'b1; i++) @(posedge core_clk);
    #1;
    chk(cal_loaded, 1'b1);
    chk(offset_coef, 14'h2034);
    chk(gain_coef, 14'h1F78);
    for (int i = 0; i < 6; i++) begin
      rd_reg(`ADCDG_ADDR_OFFSET_LOW + i[7:0], rd);
      chk(rd, RDX[i]);
    end
    wr(`ADCDG_ADDR_OFFSET_HIGH, 8'hFF);
    rd_reg(`ADCDG_ADDR_OFFSET_HIGH, rd);
    chk(rd, 8'h3F);
    chk(offset_coef, 14'h3F34);
    for (int i = 0; i < 8; i++) conv(OFS[i], GN[i], RAW[i], COR[i]);
    chk(pin_port0, core_port0);
    wr(`ADCDG_ADDR_CONTROL_TWO, 8'h40);
    rd_reg(`ADCDG_ADDR_CONTROL_TWO, rd);
    chk(rd, 8'h40);
    chk(dma_enable, 1'b1);
    @(posedge core_clk);
    core_xacc_req <= 1'b1;
    core_port0 <= '{8'h99, 1'b1};
    core_port2 <= '{8'h66, 1'b1};
    @(posedge core_clk);
    #1;
    chk(core_xacc_done, 1'b1);
    chk(core_xacc_blocked, 1'b1);
    chk(pin_port0, dma_port0);
    chk(pin_port2, dma_port2);
    @(posedge core_clk);
    core_xacc_req <= 1'b0;
    dma_block_done <= 1'b1;
    @(posedge core_clk);
    dma_block_done <= 1'b0;
    #1;
    chk(adc_irq_req, 1'b1);
    rd_reg(`ADCDG_ADDR_CONTROL_TWO, rd);
    chk(rd, 8'hC0);
    wr(`ADCDG_ADDR_CONTROL_TWO, 8'h00);
    @(posedge core_clk);
    #1;
    chk(adc_irq_req, 1'b0);
    chk(dma_enable, 1'b0);
    chk(pin_port0, core_port0);
    chk(pin_port2, core_port2);
    // Completion and software clear in one cycle: the set must win
    @(posedge core_clk);
    sfr <= '{`ADCDG_ADDR_CONTROL_TWO, 1'b1, 1'b0, 8'h00};
    dma_block_done <= 1'b1;
    @(posedge core_clk);
    sfr <= '0;
    dma_block_done <= 1'b0;
    #1;
    chk(adc_irq_req, 1'b1);
    report_and_stop();
  end
endmodule
